// [rtl/dual_counter_timing.sv]
// two up/down counters, frequency divider and their register slave
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps

module dual_counter_timing
   import dual_counter_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register bus write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // register bus write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timing pins
   input wire logic [PFI_COUNT-1:0] programmableFunctionInput,
   input wire logic digitalLineSix,
   input wire logic digitalLineSeven,
   output logic [1:0] directionLineFree,
   // monitors and results, index is the counter
   output logic [1:0] clockMonitorOut,
   output logic [1:0] clockMonitorOe,
   output logic [1:0] gateMonitorOut,
   output logic [1:0] gateMonitorOe,
   output logic [1:0] counterResultOut,
   output logic [1:0] counterResultOe,
   output logic dividedClockOut,
   output logic dividedClockOe,
   // interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // pick a pin or timebase level by select code
   function automatic logic pickLine(input logic [3:0] sel,
         input logic [PFI_COUNT-1:0] pins, input logic fast,
         input logic slow, input logic dflt);
      logic v;
      v = dflt;
      if (sel < 4'(PFI_COUNT)) begin
         v = pins[sel];
      end else if (sel == SEL_FAST) begin
         v = fast;
      end else if (sel == SEL_SLOW) begin
         v = slow;
      end
      return v;
   endfunction : pickLine

   // merge written bytes into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            v[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return v;
   endfunction : merge

   // offsets that accept a write
   function automatic logic wrOk(input logic [7:0] a);
      return a == ADDR_CFG0 || a == ADDR_CFG0 + ADDR_STEP ||
         a == ADDR_LOAD0 || a == ADDR_LOAD0 + ADDR_STEP ||
         a == ADDR_FREQ || a == ADDR_OUTEN ||
         a == ADDR_STATUS || a == ADDR_MASK;
   endfunction : wrOk

   ////////////////////////////////////////////////////////////////////
   // state

   logic [31:0] cfg [2]; // counter configuration
   logic [CNT_W-1:0] load [2]; // reload / limit value
   logic [CNT_W-1:0] count [2]; // live count
   logic [CNT_W-1:0] save [2]; // count captured by gate
   logic gateRun [2]; // start/stop state from gate
   logic srcPrev [2]; // last applied source level
   logic gatePrev [2]; // last applied gate level
   logic pulseLvl [2]; // pulse form state
   logic togLvl [2]; // toggle form state
   logic [5:0] freqCfg; // divider configuration
   logic [6:0] outEn; // output driver enables
   logic [3:0] status; // sticky events
   logic [3:0] mask; // interrupt mask
   logic [6:0] slowCnt; // slow timebase half period
   logic slowLvl; // slow timebase level
   logic fastLvl; // fastest timebase level
   logic [3:0] fCnt; // divider phase
   logic awHeld, wHeld; // write halves taken
   logic [7:0] awAddr; // held write address
   logic [31:0] wData; // held write data
   logic [3:0] wStrb; // held byte enables
   logic doWrite; // both halves present
   logic [1:0] srcApplied, gateApplied, srcEdge, gateEdge;
   logic [1:0] upDir, atLimit, stepEvt, tcEvt, gateEvt, loadWr;
   logic [1:0] dirLine; // dedicated direction lines
   logic [31:0] rdValue; // read mux value
   logic rdOk; // read offset mapped
   logic slowRise; // slow timebase rising tick
   logic [4:0] divisor; // 1..16
   logic freqHigh; // divider output before polarity
   logic [3:0] stSet, stClr; // status set and clear

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign dirLine = {digitalLineSeven, digitalLineSix};

   ////////////////////////////////////////////////////////////////////
   // timebases

   // slow level toggles every half period, fast every cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         slowCnt <= 7'h00;
         slowLvl <= 1'b0;
         fastLvl <= 1'b0;
      end else begin
         fastLvl <= ~fastLvl;
         if (slowCnt == SLOW_HALF_LAST) begin
            slowCnt <= 7'h00;
            slowLvl <= ~slowLvl;
         end else begin
            slowCnt <= slowCnt + 7'h01;
         end
      end
   end
   assign slowRise = (slowCnt == SLOW_HALF_LAST) && !slowLvl;

   ////////////////////////////////////////////////////////////////////
   // counters

   for (genvar i = 0; i < 2; i++) begin : g_ctr
      logic [7:0] cfgAddr, loadAddr;
      gate_action_t act;
      assign cfgAddr = ADDR_CFG0 + 8'(4 * i);
      assign loadAddr = ADDR_LOAD0 + 8'(4 * i);
      assign act = gate_action_t'(cfg[i][CFG_ACT_LSB +: 2]);
      assign loadWr[i] = doWrite && awAddr == loadAddr;
      // select line, then invert for falling
      assign srcApplied[i] = pickLine(cfg[i][CFG_SRC_LSB +: 4],
         programmableFunctionInput, fastLvl, slowLvl, 1'b0)
         ^ cfg[i][CFG_SRC_FALL];
      assign gateApplied[i] = pickLine(cfg[i][CFG_GATE_LSB +: 4],
         programmableFunctionInput, fastLvl, slowLvl, 1'b1)
         ^ cfg[i][CFG_GATE_FALL];
      assign srcEdge[i] = srcApplied[i] && !srcPrev[i];
      // gate sampled on core clock, may slip one edge
      assign gateEdge[i] = gateApplied[i] && !gatePrev[i];
      // line or software bit for direction
      assign upDir[i] = cfg[i][CFG_EXTDIR] ? dirLine[i]
         : cfg[i][CFG_SWUP];
      assign atLimit[i] = upDir[i] ? (count[i] == load[i])
         : (count[i] == '0);
      assign stepEvt[i] = srcEdge[i] && cfg[i][CFG_ENABLE]
         && gateRun[i];
      assign tcEvt[i] = stepEvt[i] && atLimit[i];
      assign gateEvt[i] = gateEdge[i];

      // configuration and reload registers
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            cfg[i] <= CFG_RESET;
            load[i] <= '0;
         end else begin
            if (doWrite && awAddr == cfgAddr) begin
               cfg[i] <= merge(cfg[i], wData, wStrb);
            end
            if (loadWr[i]) begin
               load[i] <= CNT_W'(merge(32'(load[i]), wData, wStrb));
            end
         end
      end

      // count, wrap at the limit, load on write
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            count[i] <= '0;
         end else if (loadWr[i]) begin
            count[i] <= CNT_W'(merge(32'(load[i]), wData, wStrb));
         end else if (stepEvt[i]) begin
            if (atLimit[i]) begin
               count[i] <= upDir[i] ? '0 : load[i];
            end else if (upDir[i]) begin
               count[i] <= count[i] + CNT_W'(1);
            end else begin
               count[i] <= count[i] - CNT_W'(1);
            end
         end
      end

      // gate actions and edge history
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            gateRun[i] <= 1'b1;
            save[i] <= '0;
            srcPrev[i] <= 1'b0;
            gatePrev[i] <= 1'b0;
         end else begin
            srcPrev[i] <= srcApplied[i];
            gatePrev[i] <= gateApplied[i];
            if (act != ACT_STARTSTOP) begin
               gateRun[i] <= 1'b1;
            end else if (gateEdge[i]) begin
               gateRun[i] <= ~gateRun[i];
            end
            if (gateEdge[i] && act == ACT_SAVE) begin
               save[i] <= count[i];
            end
         end
      end

      // terminal count forms
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            pulseLvl[i] <= 1'b0;
            togLvl[i] <= 1'b0;
         end else begin
            // pulse held until the next source edge
            if (tcEvt[i]) begin
               pulseLvl[i] <= 1'b1;
            end else if (srcEdge[i]) begin
               pulseLvl[i] <= 1'b0;
            end
            // toggle form flips on each terminal count
            if (tcEvt[i]) begin
               togLvl[i] <= ~togLvl[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frequency divider

   // divide the chosen input by 1..16
   assign divisor = (freqCfg[FREQ_DIV_LSB +: 4] == 4'h0) ? 5'h10
      : {1'b0, freqCfg[FREQ_DIV_LSB +: 4]};
   // high for the first (divisor+1)/2 counts of each cycle
   assign freqHigh = {1'b0, fCnt} < ((divisor + 5'h01) >> 1);

   // phase counter, restarted by any write of its setup
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fCnt <= 4'h0;
      end else if (doWrite && awAddr == ADDR_FREQ) begin
         fCnt <= 4'h0;
      end else if (freqCfg[FREQ_SLOW] ? slowRise : 1'b1) begin
         fCnt <= ({1'b0, fCnt} == divisor - 5'h01) ? 4'h0
            : fCnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins

   // every pin from a flip-flop, drivers off after reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         clockMonitorOut <= 2'h0;
         clockMonitorOe <= 2'h0;
         gateMonitorOut <= 2'h0;
         gateMonitorOe <= 2'h0;
         counterResultOut <= 2'h0;
         counterResultOe <= 2'h0;
         dividedClockOut <= 1'b0;
         dividedClockOe <= 1'b0;
         directionLineFree <= 2'h3;
      end else begin
         for (int i = 0; i < 2; i++) begin
            // copy the applied source and gate
            clockMonitorOut[i] <= srcApplied[i];
            gateMonitorOut[i] <= gateApplied[i];
            counterResultOut[i] <= (cfg[i][CFG_TOGGLE] ? togLvl[i]
               : pulseLvl[i]) ^ cfg[i][CFG_INVERT];
            // line free while its input is off
            directionLineFree[i] <= !cfg[i][CFG_EXTDIR];
         end
         dividedClockOut <= freqHigh ^ freqCfg[FREQ_INVERT];
         clockMonitorOe <= outEn[OE_SRC_LSB +: 2];
         gateMonitorOe <= outEn[OE_GATE_LSB +: 2];
         counterResultOe <= outEn[OE_OUT_LSB +: 2];
         dividedClockOe <= outEn[OE_FREQ];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status and interrupt

   assign stSet = {gateEvt, tcEvt};
   assign stClr = (doWrite && awAddr == ADDR_STATUS && wStrb[0])
      ? wData[3:0] : 4'h0;

   // sticky events, a new event beats a clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= 4'h0;
         irq <= 1'b0;
      end else begin
         status <= (status & ~stClr) | stSet;
         irq <= |(status & mask);
      end
   end

   // plain software registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         freqCfg <= 6'h00;
         outEn <= 7'h00;
         mask <= 4'h0;
      end else if (doWrite && wStrb[0]) begin
         if (awAddr == ADDR_FREQ) freqCfg <= wData[5:0];
         if (awAddr == ADDR_OUTEN) outEn <= wData[6:0];
         if (awAddr == ADDR_MASK) mask <= wData[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register bus

   // write channels taken in either order, one answer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk(awAddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read mux, unmapped reads zero with error
   always_comb begin
      rdValue = 32'h00000000;
      rdOk = 1'b1;
      case (s_axi_araddr)
         ADDR_CFG0: rdValue = cfg[0];
         ADDR_CFG0 + ADDR_STEP: rdValue = cfg[1];
         ADDR_LOAD0: rdValue = 32'(load[0]);
         ADDR_LOAD0 + ADDR_STEP: rdValue = 32'(load[1]);
         ADDR_COUNT0: rdValue = 32'(count[0]);
         ADDR_COUNT0 + ADDR_STEP: rdValue = 32'(count[1]);
         ADDR_SAVE0: rdValue = 32'(save[0]);
         ADDR_SAVE0 + ADDR_STEP: rdValue = 32'(save[1]);
         ADDR_FREQ: rdValue = 32'(freqCfg);
         ADDR_OUTEN: rdValue = 32'(outEn);
         ADDR_STATUS: rdValue = 32'(status);
         ADDR_MASK: rdValue = 32'(mask);
         default: rdOk = 1'b0;
      endcase
   end

   // read answer one cycle after the address
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdValue;
         s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   property p_oe_off;
      @(posedge core_clk) disable iff (!reset_n)
      !outEn[OE_OUT_LSB] |=> !counterResultOe[0];
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("result driver on while disabled");

   property p_src_mon;
      @(posedge core_clk) disable iff (!reset_n)
      srcEdge[0] |=> clockMonitorOut[0] && !$past(clockMonitorOut[0]);
   endproperty
   a_src_mon: assert property (p_src_mon)
      else $error("source monitor missed an edge");

   property p_gate_mon;
      @(posedge core_clk) disable iff (!reset_n)
      ##1 gateMonitorOut[1] == $past(gateApplied[1]);
   endproperty
   a_gate_mon: assert property (p_gate_mon)
      else $error("gate monitor differs from gate");

   property p_down;
      @(posedge core_clk) disable iff (!reset_n)
      stepEvt[0] && cfg[0][CFG_EXTDIR] && !digitalLineSix
      && !atLimit[0] && !loadWr[0] |=> count[0] == $past(count[0]) - 1;
   endproperty
   a_down: assert property (p_down)
      else $error("counter zero failed to count down");

   property p_up;
      @(posedge core_clk) disable iff (!reset_n)
      stepEvt[1] && cfg[1][CFG_EXTDIR] && digitalLineSeven
      && !atLimit[1] && !loadWr[1] |=> count[1] == $past(count[1]) + 1;
   endproperty
   a_up: assert property (p_up)
      else $error("counter one failed to count up");

   property p_pulse;
      @(posedge core_clk) disable iff (!reset_n)
      tcEvt[0] && !cfg[0][CFG_TOGGLE] && $stable(cfg[0]) |=> ##1
      counterResultOut[0] == !cfg[0][CFG_INVERT];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("terminal count pulse missing");

   property p_save;
      @(posedge core_clk) disable iff (!reset_n)
      gateEdge[1] && cfg[1][CFG_ACT_LSB +: 2] == 2'h3
      |=> save[1] == $past(count[1]);
   endproperty
   a_save: assert property (p_save)
      else $error("gate edge did not save count");

   property p_fcnt;
      @(posedge core_clk) disable iff (!reset_n)
      {1'b0, fCnt} < divisor;
   endproperty
   a_fcnt: assert property (p_fcnt)
      else $error("divider phase beyond divisor");

   property p_irq;
      @(posedge core_clk) disable iff (!reset_n)
      (stSet & mask) != 4'h0 |=> ##1 irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked event raised no interrupt");

endmodule : dual_counter_timing

// [include/dual_counter_pkg.sv]
// constants shared by the dual counter and frequency divider block
package dual_counter_pkg;
   // core clock and timebases
   localparam int CLK_HZ = 10_000_000;
   localparam int FAST_TB_HZ = 20_000_000;
   localparam int SLOW_TB_HZ = 100_000;
   localparam int FREQ_FAST_HZ = 10_000_000;
   localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_TB_HZ);
   localparam logic [6:0] SLOW_HALF_LAST = 7'(SLOW_HALF - 1);
   // pins and widths
   localparam int PFI_COUNT = 10;
   localparam int CNT_W = 24;
   localparam logic [3:0] SEL_FAST = 4'hA;
   localparam logic [3:0] SEL_SLOW = 4'hB;
   // register byte offsets
   localparam logic [7:0] ADDR_CFG0 = 8'h00;
   localparam logic [7:0] ADDR_LOAD0 = 8'h08;
   localparam logic [7:0] ADDR_COUNT0 = 8'h10;
   localparam logic [7:0] ADDR_SAVE0 = 8'h18;
   localparam logic [7:0] ADDR_FREQ = 8'h20;
   localparam logic [7:0] ADDR_OUTEN = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_MASK = 8'h2C;
   localparam logic [7:0] ADDR_STEP = 8'h04;
   // counter configuration fields
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_SRC_FALL = 4;
   localparam int CFG_GATE_LSB = 5;
   localparam int CFG_GATE_FALL = 9;
   localparam int CFG_ACT_LSB = 10;
   localparam int CFG_ENABLE = 12;
   localparam int CFG_TOGGLE = 13;
   localparam int CFG_INVERT = 14;
   localparam int CFG_EXTDIR = 15;
   localparam int CFG_SWUP = 16;
   localparam logic [31:0] CFG_RESET = 32'h0000000A;
   // frequency divider fields
   localparam int FREQ_DIV_LSB = 0;
   localparam int FREQ_SLOW = 4;
   localparam int FREQ_INVERT = 5;
   // output enable and status bits
   localparam int OE_SRC_LSB = 0;
   localparam int OE_GATE_LSB = 2;
   localparam int OE_OUT_LSB = 4;
   localparam int OE_FREQ = 6;
   localparam int ST_TC_LSB = 0;
   localparam int ST_GATE_LSB = 2;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // gate edge actions
   typedef enum logic [1:0] {ACT_NONE, ACT_STARTSTOP, ACT_IRQ, ACT_SAVE}
      gate_action_t;
endpackage : dual_counter_pkg

// [verification/far_side_model.sv]
// external source pin driver for the counter inputs
`timescale 1ns/10ps
module far_side_model
   import dual_counter_pkg::*;
(
   // clock and control
   input wire logic core_clk,
   input wire logic run,
   // pins and toggle tally
   output logic [PFI_COUNT-1:0] pins,
   output int toggles
);
   logic [1:0] phase = 2'h0; // cycles into half period
   initial pins = '0;
   initial toggles = 0;
   // half period of three core cycles
   always @(posedge core_clk) begin
      if (run) begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         if (phase == 2'h2) begin
            pins[3] <= ~pins[3];
            toggles <= toggles + 1;
         end
      end
   end
endmodule : far_side_model

// [verification/dual_counter_timing_test.sv]
// self-checking bench for the dual counter block
`timescale 1ns/10ps
module dual_counter_timing_test;
   import dual_counter_pkg::*;
   logic core_clk = 0, reset_n = 0, run = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic digitalLineSix = 1, digitalLineSeven = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, dividedClockOut, dividedClockOe, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, directionLineFree;
   logic [1:0] clockMonitorOut, clockMonitorOe, gateMonitorOut;
   logic [1:0] gateMonitorOe, counterResultOut, counterResultOe;
   logic [PFI_COUNT-1:0] programmableFunctionInput;
   int toggles, nFail = 0, cmpCount = 0;
   always #50 core_clk = ~core_clk;
   dual_counter_timing DUT (.*);
   far_side_model far (.core_clk, .run,
      .pins(programmableFunctionInput), .toggles);
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nFail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   // bus write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 60 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
      if (n >= 60) begin nFail++; final_report(); end
      @(posedge core_clk);
   endtask : wr
   // bus read
   task automatic rdr(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 60 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 0;
      if (n >= 60) begin nFail++; final_report(); end
      @(posedge core_clk);
   endtask : rdr
   // divider widths for one divisor code
   task automatic freq(input logic [3:0] code, input logic inv,
         input logic slow);
      int d, hi, lo, n, p;
      d = (code == 0) ? 16 : code;
      p = slow ? 2 * SLOW_HALF : 1;
      wr(ADDR_FREQ, {26'h0, inv, slow, code});
      for (n = 0; n < 4000 && dividedClockOut !== 1'b0; n++) tick(1);
      for (n = 0; n < 4000 && dividedClockOut !== 1'b1; n++) tick(1);
      for (hi = 0; hi < 4000 && dividedClockOut === 1'b1; hi++) tick(1);
      for (lo = 0; lo < 4000 && dividedClockOut === 1'b0; lo++) tick(1);
      check(32'(hi), 32'(p * (inv ? d / 2 : (d + 1) / 2)));
      check(32'(lo), 32'(p * (inv ? (d + 1) / 2 : d / 2)));
   endtask : freq
   // source edges from the far side
   task automatic run_edges(input int k);
      int n, t;
      t = toggles + 2 * k;
      run <= 1;
      for (n = 0; n < 999 && toggles < t; n++) tick(1);
      run <= 0;
      tick(6);
   endtask : run_edges
   ////////////////////////////////////////////////////////////////////
   initial begin
      int i, k, ld, c;
      logic [7:0] a;
      void'($urandom(17));
      tick(6);
      reset_n <= 1;
      tick(1);
      check({clockMonitorOe, gateMonitorOe, counterResultOe,
         dividedClockOe}, 0);
      check(directionLineFree, 2'h3);
      rdr(ADDR_CFG0);
      check(rd, CFG_RESET);
      rdr(8'h30);
      check(rd, 0);
      check(rsp, RESP_SLVERR);
      wr(ADDR_OUTEN, 32'h7F);
      check({clockMonitorOe, gateMonitorOe, counterResultOe,
         dividedClockOe}, 7'h7F);
      // per counter: pin three source, gate high, ext direction
      for (i = 0; i < 2; i++) begin
         ld = $urandom_range(9, 2);
         k = $urandom_range(12, 3);
         a = 8'(i * 4);
         {digitalLineSeven, digitalLineSix} <= 2'h3;
         wr(ADDR_CFG0 + a, 32'h000091E3 | 32'(i << CFG_SRC_FALL));
         wr(ADDR_LOAD0 + a, 32'(ld));
         check(directionLineFree[i], 0);
         run_edges(k);
         rdr(ADDR_COUNT0 + a);
         c = (ld + k) % (ld + 1);
         check(rd, 32'(c));
         check(clockMonitorOut[i], i[0]);
         check(gateMonitorOut[i], 1);
         check(counterResultOut[i], c == 0);
         {digitalLineSeven, digitalLineSix} <= 2'h0;
         run_edges(k);
         rdr(ADDR_COUNT0 + a);
         c = (c + 4 * (ld + 1) - k) % (ld + 1);
         check(rd, 32'(c));
         check(counterResultOut[i], c == ld);
         rdr(ADDR_STATUS);
         check(rd[i], 1);
      end
      // interrupt masked, unmasked, cleared
      check(irq, 0);
      wr(ADDR_MASK, 32'h3);
      tick(2);
      check(irq, 1);
      wr(ADDR_STATUS, 32'hF);
      tick(2);
      check(irq, 0);
      freq(4'h2, 0, 0);
      freq(4'h0, 1, 0);
      freq(4'h3, 0, 1);
      for (i = 0; i < 2; i++) freq(4'($urandom_range(15, 3)), i[0], 0);
      final_report();
   end
endmodule : dual_counter_timing_test
